// ===== rtl/pot_pkg.sv
package pot_pkg;

   // word layout, sent msb first
   localparam int WORD_BITS = 16;
   localparam int DATA_BITS = 10;
   localparam int CMD_LSB = 10;
   localparam int CMD_MSB = 13;
   localparam int CNT_BITS = 4;

   localparam logic [9:0] WIPER_MIDSCALE = 10'h200;
   localparam logic [15:0] SHIFT_RESET = 16'h0000;
   localparam logic [5:0] READBACK_PAD = 6'h00;

   localparam logic [3:0] CMD_NOP = 4'h0;
   localparam logic [3:0] CMD_WRITE_WIPER = 4'h1;
   localparam logic [3:0] CMD_READ_WIPER = 4'h2;

   // execution times; the part leaves them open, so these are defaults
   localparam int CLK_MHZ = 40;
   localparam int EXEC_WRITE_NS = 100;
   localparam int EXEC_READ_NS = 100;
   localparam int EXEC_WRITE_CYC = (EXEC_WRITE_NS * CLK_MHZ + 999) / 1000;
   localparam int EXEC_READ_CYC = (EXEC_READ_NS * CLK_MHZ + 999) / 1000;
   localparam int BUSY_BITS = 5;

   // open-drain pin as seen by the module: oe_n low means pulling low
   typedef struct packed {
      logic out;
      logic oe_n;
   } od_pin_s;

endpackage : pot_pkg

// ===== rtl/pot_serial_frame_interface.sv
// Behaviour
// - rising edge of hardware reset pin loads wiper with midscale.
// - sixteen-bit shift register captures data input on falling serial clock.
// - frame starts with frame sync low; shifting only while it is low.
// - frame sync rise after sixteenth edge decodes and applies the word.
// - frame sync rise before sixteen edges aborts; no register changes.
// - shift register contents leave on serial output for chain or readback.
// - serial output is open drain, pulling low only.
// - ready output is open drain and returns high when command finishes.
// - word is msb first: two zero bits, four command, ten data bits.
// - clock edges are counted modulo sixteen, so 32-bit frames work.
// - two chained devices take 32 bits; last sixteen stay here.
// - after readback, wiper contents leave on the next frame.
`timescale 1ns/1ps
module pot_serial_frame_interface (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // host pins, asynchronous to clk
   input wire logic sclk,
   input wire logic sync_n,
   input wire logic din,
   input wire logic hw_reset_n,
   // open-drain outputs
   output pot_pkg::od_pin_s serial_out_od,
   output pot_pkg::od_pin_s ready_od,
   // wiper position to the resistor network
   output logic [pot_pkg::DATA_BITS-1:0] wiper_position_reg
);
   import pot_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers: bit 0 sclk, 1 sync_n, 2 din, 3 hw_reset_n
   logic [3:0] pin_meta;
   logic [3:0] pin_sync;
   logic [3:0] pin_last;
   wire [3:0] pin_raw = {hw_reset_n, din, sync_n, sclk};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_meta <= 4'b1010;
         pin_sync <= 4'b1010;
         pin_last <= 4'b1010;
      end else begin
         pin_meta <= pin_raw;
         pin_sync <= pin_meta;
         pin_last <= pin_sync;
      end
   end

   wire sclk_fall = pin_last[0] & ~pin_sync[0];
   wire sclk_rise = ~pin_last[0] & pin_sync[0];
   wire sync_low = ~pin_sync[1];
   wire sync_fall = pin_last[1] & ~pin_sync[1];
   wire sync_rise = ~pin_last[1] & pin_sync[1];
   wire din_s = pin_sync[2];
   wire hrst_rise = ~pin_last[3] & pin_sync[3];

   ////////////////////////////////////////////////////////////////////////
   // shift register and edge counter
   logic [WORD_BITS-1:0] shreg;
   logic [CNT_BITS-1:0] bit_cnt;
   logic full_word;

   wire shift_en = sclk_fall & sync_low;
   // whole multiple of sixteen edges seen in this frame
   wire frame_ok = full_word & (bit_cnt == '0);
   wire [3:0] cmd = shreg[CMD_MSB:CMD_LSB];
   wire do_write = sync_rise & frame_ok & (cmd == CMD_WRITE_WIPER);
   wire do_read = sync_rise & frame_ok & (cmd == CMD_READ_WIPER);
   wire [WORD_BITS-1:0] readback_word = {READBACK_PAD, wiper_position_reg};
   wire [WORD_BITS-1:0] shifted = {shreg[WORD_BITS-2:0], din_s};
   wire [WORD_BITS-1:0] next_shreg = do_read ? readback_word :
                                     shift_en ? shifted : shreg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         shreg <= SHIFT_RESET;
      end else begin
         shreg <= next_shreg;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bit_cnt <= '0;
         full_word <= 1'b0;
      end else if (sync_fall) begin
         bit_cnt <= '0;
         full_word <= 1'b0;
      end else if (shift_en) begin
         bit_cnt <= bit_cnt + 4'd1;
         if (bit_cnt == 4'hf) begin
            full_word <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // wiper position; the reset pin wins over a write in the same cycle

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wiper_position_reg <= WIPER_MIDSCALE;
      end else if (hrst_rise) begin
         wiper_position_reg <= WIPER_MIDSCALE;
      end else if (do_write) begin
         wiper_position_reg <= shreg[DATA_BITS-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // serial output: new bit on rising sclk so the next device can sample
   // it on the following falling edge; released outside frames

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         serial_out_od <= '{out: 1'b0, oe_n: 1'b1};
      end else if (!sync_low) begin
         serial_out_od <= '{out: 1'b0, oe_n: 1'b1};
      end else if (sync_fall | sclk_rise) begin
         serial_out_od <= '{out: 1'b0, oe_n: shreg[WORD_BITS-1]};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // ready: busy count runs from the frame end that starts a command
   logic [BUSY_BITS-1:0] busy_cnt;
   wire [BUSY_BITS-1:0] wr_cyc = BUSY_BITS'(EXEC_WRITE_CYC);
   wire [BUSY_BITS-1:0] rd_cyc = BUSY_BITS'(EXEC_READ_CYC);
   wire [BUSY_BITS-1:0] next_busy = do_read ? rd_cyc :
                                    (sync_rise & frame_ok) ? wr_cyc :
                                    (busy_cnt != '0) ? busy_cnt - 5'd1 :
                                    busy_cnt;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy_cnt <= '0;
      end else begin
         busy_cnt <= next_busy;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ready_od <= '{out: 1'b0, oe_n: 1'b1};
      end else begin
         ready_od <= '{out: 1'b0, oe_n: (next_busy == '0)};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   a_midscale_load:
   assert property (@(posedge clk) disable iff (rst)
      hrst_rise |=> wiper_position_reg == WIPER_MIDSCALE)
      else $error("wiper not at midscale after reset pin rise");

   a_shift_capture:
   assert property (@(posedge clk) disable iff (rst)
      shift_en && !sync_rise |=>
         shreg == {$past(shreg[WORD_BITS-2:0]), $past(din_s)})
      else $error("shift register did not capture data input");

   a_idle_no_shift:
   assert property (@(posedge clk) disable iff (rst)
      sclk_fall && !sync_low && !sync_rise |=> $stable(shreg))
      else $error("shift register moved with frame sync high");

   a_apply_write:
   assert property (@(posedge clk) disable iff (rst)
      do_write && !hrst_rise |=>
         wiper_position_reg == $past(shreg[DATA_BITS-1:0]))
      else $error("complete write frame not applied");

   a_abort_keep:
   assert property (@(posedge clk) disable iff (rst)
      sync_rise && !frame_ok && !hrst_rise |=> $stable(wiper_position_reg))
      else $error("aborted frame changed the wiper");

   a_sdo_follow:
   assert property (@(posedge clk) disable iff (rst)
      sclk_rise && sync_low && !sync_fall |=>
         serial_out_od.oe_n == $past(shreg[WORD_BITS-1]))
      else $error("serial output does not follow shift register");

   a_sdo_drain:
   assert property (@(posedge clk) disable iff (rst)
      serial_out_od.out == 1'b0)
      else $error("serial output drives high");

   a_busy_ready:
   assert property (@(posedge clk) disable iff (rst)
      sync_rise && frame_ok |=> !ready_od.oe_n ##[1:20] ready_od.oe_n)
      else $error("ready not low then released after command");

   a_ready_drain:
   assert property (@(posedge clk) disable iff (rst)
      busy_cnt == '0 && !sync_rise |=> ready_od.oe_n && !ready_od.out)
      else $error("ready held low while idle");

   a_readback_load:
   assert property (@(posedge clk) disable iff (rst)
      do_read |=> shreg == {READBACK_PAD, $past(wiper_position_reg)})
      else $error("readback word not loaded");

endmodule : pot_serial_frame_interface

// ===== verif/pot_host_model.sv
`timescale 1ns/1ps
module pot_host_model (
   // link pins driven by the host
   output logic sclk,
   output logic sync_n,
   output logic din,
   // open-drain return from the device
   input wire pot_pkg::od_pin_s serial_out_od
);
   import pot_pkg::*;
   // pull-up: a released pin reads high
   wire sdo_level = serial_out_od.oe_n ? 1'b1 : 1'b0;
   initial begin
      sclk = 1'b0;
      sync_n = 1'b1;
      din = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   // sync low, msb first, n bits, sync high
   task automatic frame(input logic [31:0] w, input int n,
                        output logic [31:0] rd);
      rd = 32'h0000_0000;
      // step off the clk edge so no change races the sampler
      #7 sync_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         #50 din = w[i];
         #50 sclk = 1'b1;
         // data held across the falling edge
         #100 rd = {rd[30:0], sdo_level};
         sclk = 1'b0;
      end
      #100 sync_n = 1'b1;
      // stale data is never left on the line
      din = ~din;
      #200;
   endtask : frame
   // clock pulses with sync high, which the device must ignore
   task automatic stray(input int n);
      for (int i = 0; i < n; i++) begin
         #50 din = ~din;
         #50 sclk = 1'b1;
         #100 sclk = 1'b0;
      end
      #100;
   endtask : stray
endmodule : pot_host_model

// ===== verif/tb_pot_serial_frame_interface.sv
`timescale 1ns/1ps
module tb_pot_serial_frame_interface;
   import pot_pkg::*;
   logic clk, rst, sclk, sync_n, din, hw_reset_n;
   od_pin_s serial_out_od, ready_od;
   logic [DATA_BITS-1:0] wiper_position_reg, last_wiper, d, cur;
   logic [DATA_BITS-1:0] exp_q[$];
   logic [31:0] rd, prev;
   int n_mismatch = 0;
   int num_checks = 0;
   int busy_len = 0;
   int n_busy = 0;
   int n_frames = 0;
   int busy_exp = EXEC_WRITE_CYC;
   integer seed = 95421;

   pot_serial_frame_interface pot_serial_frame_interface_i (.clk(clk),
      .rst(rst), .sclk(sclk), .sync_n(sync_n), .din(din),
      .hw_reset_n(hw_reset_n), .serial_out_od(serial_out_od),
      .ready_od(ready_od), .wiper_position_reg(wiper_position_reg));
   pot_host_model pot_host_model_i (.sclk(sclk), .sync_n(sync_n),
      .din(din), .serial_out_od(serial_out_od));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic results;
      if (n_mismatch == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : results

   task automatic send(input logic [15:0] w0, w1, input int n);
      busy_exp = (w1[CMD_MSB:CMD_LSB] == CMD_READ_WIPER) ? EXEC_READ_CYC :
                 EXEC_WRITE_CYC;
      @(posedge clk);
      pot_host_model_i.frame({w0, w1}, n, rd);
      if (n % 16 == 0) n_frames++;
   endtask : send
   ////////////////////////////////////////////////////////////////////////
   // any wiper change must match the oldest note
   always @(posedge clk) begin
      if (!rst && wiper_position_reg !== last_wiper) begin
         if (exp_q.size() == 0) check(wiper_position_reg, last_wiper);
         else check(wiper_position_reg, exp_q.pop_front());
      end
      last_wiper <= wiper_position_reg;
   end

   always @(posedge clk) begin
      if (ready_od.oe_n === 1'b0) busy_len <= busy_len + 1;
      else if (busy_len != 0) begin
         check(busy_len, busy_exp);
         n_busy <= n_busy + 1;
         busy_len <= 0;
      end
   end

   initial begin
      #200_000;
      n_mismatch++;
      results();
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      hw_reset_n = 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check(wiper_position_reg, WIPER_MIDSCALE);
      check({serial_out_od, ready_od}, 4'h5);
      cur = WIPER_MIDSCALE;
      prev = {16'h0000, SHIFT_RESET};
      // full-scale, zero, then random codes
      for (int i = 0; i < 6; i++) begin
         d = (i == 0) ? 10'h3ff : (i == 1) ? 10'h000 : 10'($random(seed));
         if (d === cur) d = ~d;
         exp_q.push_back(d);
         cur = d;
         if (i == 3) pot_host_model_i.stray(3);
         send(16'h0000, {2'b00, CMD_WRITE_WIPER, d}, 16);
         check(rd[15:0], prev[15:0]);
         prev = {16'h0000, 2'b00, CMD_WRITE_WIPER, d};
      end
      // short frame must leave the wiper alone
      send(16'h0000, {2'b00, CMD_WRITE_WIPER, ~cur}, 15);
      d = (cur === 10'h2aa) ? 10'h0f0 : 10'h2aa;
      exp_q.push_back(d);
      cur = d;
      send({2'b00, CMD_WRITE_WIPER, 10'h155},
           {2'b00, CMD_WRITE_WIPER, d}, 32);
      check(rd[15:0], {2'b00, CMD_WRITE_WIPER, 10'h155});
      send(16'h0000, {2'b00, CMD_READ_WIPER, 10'h000}, 16);
      check(rd[15:0], {2'b00, CMD_WRITE_WIPER, cur});
      send(16'h0000, 16'h0000, 16);
      check(rd[15:0], {READBACK_PAD, cur});
      exp_q.push_back(WIPER_MIDSCALE);
      @(posedge clk);
      hw_reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      hw_reset_n <= 1'b1;
      repeat (10) @(posedge clk);
      check(n_busy, n_frames);
      check(exp_q.size(), 0);
      check(ready_od, 2'b01);
      results();
   end
endmodule : tb_pot_serial_frame_interface
